// ===== pci_irq_line_router.sv
// Shared request line router onto legacy and extended system IRQs
//
// Overview of operation
// - Legacy mode drives only system IRQs 0 through 15.
// - Extended mode offers twenty-four system IRQs, 0 through 23.
// - IRQs 16..23 exist only in extended mode, fed by lines A..H.
// - Eight shared request lines; each PCI source wires to exactly one.
// - Legacy mode steers each line to 3-7, 9-12, 14 or 15.
// - Several lines may share one IRQ; any active line asserts it.
// - IRQ 2 carries the secondary controller cascade, never assignable.
// - IRQs 0, 1, 8, 13: timer, keyboard, real-time clock, coprocessor.
// - Serial port defaults to IRQ 4, parallel to 7; both movable.
// - IRQ 14 serves the ATA controller if present, else assignable.
// - IRQ 12 serves the mouse port if present, else assignable.
// - Fixed board wiring of 1394 and slot pins onto lines A..H.
// - Sources on one line share one interrupt.
// - USB, SATA and PCIe function IRQs are assigned at configuration.
`timescale 1ns/1ps
module pci_irq_line_router #(
	parameter int DYN_NUM = irq_router_pkg::DYN_NUM
) (
	input wire logic i_ref_clk,
	input wire logic i_nrst,
	input wire irq_router_pkg::pci_src_t i_pci_int_n,
	input wire irq_router_pkg::legacy_src_t i_legacy_req,
	input wire logic [DYN_NUM-1:0] i_dyn_req,
	input wire logic i_extended_vector_mode,
	input wire logic i_mouse_present,
	input wire logic i_ata_present,
	input wire irq_router_pkg::steer_t [7:0] i_line_steer,
	input wire irq_router_pkg::steer_t i_serial_steer,
	input wire irq_router_pkg::steer_t i_parallel_steer,
	input wire irq_router_pkg::steer_t [DYN_NUM-1:0] i_dyn_steer,
	output logic [23:0] o_irq,
	output logic [7:0] o_line_active
);

	localparam int SYNC_W = irq_router_pkg::PCI_SRC_W
		+ irq_router_pkg::LEGACY_SRC_W + DYN_NUM;
	// Active-low pins idle high, active-high requests idle low
	localparam logic [SYNC_W-1:0] SYNC_RST =
		{{irq_router_pkg::PCI_SRC_W{1'b1}},
		{(SYNC_W - irq_router_pkg::PCI_SRC_W){1'b0}}};

	irq_router_pkg::pci_src_t pci_q;
	irq_router_pkg::legacy_src_t leg_q;
	logic [DYN_NUM-1:0] dyn_q;
	logic [SYNC_W-1:0] sync_out;
	logic [7:0] line_act;
	logic [23:0] irq_next;
	logic [23:0] irq_reg;

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisation

	irq_pin_filter #(
		.WIDTH(SYNC_W),
		.RST_VAL(SYNC_RST)
	) u_pin_filter (
		.i_ref_clk(i_ref_clk),
		.i_nrst(i_nrst),
		.i_pin({i_pci_int_n, i_legacy_req, i_dyn_req}),
		.o_level(sync_out)
	);

	assign {pci_q, leg_q, dyn_q} = sync_out;

	////////////////////////////////////////////////////////////////////////
	// Helpers

	// Reserved numbers and present devices are never taken by steering
	function automatic logic irq_legal(input logic [3:0] num,
		input logic mouse_p, input logic ata_p);
		logic ok;
		ok = irq_router_pkg::IRQ_STEER_MASK[num];
		if (mouse_p && num == irq_router_pkg::IRQ_MOUSE)
			ok = 1'b0;
		if (ata_p && num == irq_router_pkg::IRQ_ATA)
			ok = 1'b0;
		return ok;
	endfunction

	// OR one request into the IRQ vector; illegal targets drop it
	function automatic logic [23:0] route_or(input logic [23:0] vec,
		input logic [3:0] num, input logic act,
		input logic mouse_p, input logic ata_p);
		logic [23:0] res;
		res = vec;
		if (act && irq_legal(num, mouse_p, ata_p))
			res[num] = 1'b1;
		return res;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Shared line wired-OR

	always_comb
	begin
		line_act = 8'h00;
		if (!pci_q.fw_int_n)
			line_act[irq_router_pkg::FW_LINE] = 1'b1;
		for (int s = 0; s < irq_router_pkg::SLOT_NUM; s++)
		begin
			for (int p = 0; p < irq_router_pkg::PIN_NUM; p++)
			begin
				// Low level on any source holds the line active
				if (!pci_q.slot_int_n[s][p])
					line_act[irq_router_pkg::SLOT_LINE[s][p]] = 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// IRQ vector build

	always_comb
	begin
		irq_next = 24'h000000;
		irq_next[irq_router_pkg::IRQ_TIMER] = leg_q.timer;
		irq_next[irq_router_pkg::IRQ_KBD] = leg_q.kbd;
		irq_next[irq_router_pkg::IRQ_CASCADE] = leg_q.cascade;
		irq_next[irq_router_pkg::IRQ_FLOPPY] = leg_q.floppy;
		irq_next[irq_router_pkg::IRQ_RTC] = leg_q.rtc;
		irq_next[irq_router_pkg::IRQ_COPRO] = leg_q.copro;
		if (i_mouse_present)
			irq_next[irq_router_pkg::IRQ_MOUSE] = leg_q.mouse;
		if (i_ata_present)
			irq_next[irq_router_pkg::IRQ_ATA] = leg_q.ata;
		irq_next = route_or(irq_next,
			i_serial_steer.en ? i_serial_steer.irq
			: irq_router_pkg::IRQ_SERIAL_DEF,
			leg_q.first_serial_port,
			i_mouse_present, i_ata_present);
		irq_next = route_or(irq_next,
			i_parallel_steer.en ? i_parallel_steer.irq
			: irq_router_pkg::IRQ_PARALLEL_DEF,
			leg_q.first_parallel_port,
			i_mouse_present, i_ata_present);
		for (int d = 0; d < DYN_NUM; d++)
		begin
			// Unassigned functions stay silent
			irq_next = route_or(irq_next, i_dyn_steer[d].irq,
				dyn_q[d] && i_dyn_steer[d].en,
				i_mouse_present, i_ata_present);
		end
		if (i_extended_vector_mode)
		begin
			// Lines bypass steering and own the upper eight
			irq_next[irq_router_pkg::IRQ_EXT_BASE +: 8] = line_act;
		end
		else
		begin
			for (int i = 0; i < irq_router_pkg::LINE_NUM; i++)
			begin
				irq_next = route_or(irq_next, i_line_steer[i].irq,
					line_act[i] && i_line_steer[i].en,
					i_mouse_present, i_ata_present);
			end
			irq_next[23:16] = 8'h00;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_nrst)
	begin
		if (!i_nrst)
			irq_reg <= 24'h000000;
		else
			irq_reg <= irq_next;
	end

	assign o_irq = irq_reg;
	assign o_line_active = line_act;

	////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_nrst);

	// Pin held low, or high, across the full synchroniser depth
	sequence s_slot3_inta_held;
		(!i_pci_int_n.slot_int_n[2][0]) [*4];
	endsequence

	sequence s_slot3_inta_idle;
		(i_pci_int_n.slot_int_n[2][0]) [*4];
	endsequence

	sequence s_line_a_steered_to_3;
		!i_extended_vector_mode && i_line_steer[0].en
		&& i_line_steer[0].irq == 4'h3 && line_act[0];
	endsequence

	a_legacy_upper_quiet: assert property (
		!$past(i_extended_vector_mode) |-> o_irq[23:16] == 8'h00)
		else $error("Upper IRQs driven in legacy mode");

	a_ext_line_map: assert property (
		$past(i_extended_vector_mode) |-> o_irq[23:16] == $past(line_act))
		else $error("Extended IRQs do not follow lines A to H");

	a_cascade_fixed: assert property (
		o_irq[2] == $past(leg_q.cascade))
		else $error("IRQ 2 not pure cascade");

	a_reserved_fixed: assert property (
		o_irq[13] == $past(leg_q.copro) && o_irq[8] == $past(leg_q.rtc)
		&& o_irq[0] == $past(leg_q.timer))
		else $error("Reserved IRQ disturbed");

	a_wired_slot3_inta: assert property (
		s_slot3_inta_held |=> line_act[2])
		else $error("Slot 3 INTA did not reach line C");

	a_steer_shared: assert property (
		s_line_a_steered_to_3 |=> o_irq[3])
		else $error("Steered line did not assert its IRQ");

	a_serial_default: assert property (
		leg_q.first_serial_port && !i_serial_steer.en |=> o_irq[4])
		else $error("Serial request missing on default IRQ");

	a_mouse_reserve: assert property (
		$past(i_mouse_present) |-> o_irq[12] == $past(leg_q.mouse))
		else $error("IRQ 12 not owned by mouse port");

	a_ata_reserve: assert property (
		$past(i_ata_present) |-> o_irq[14] == $past(leg_q.ata))
		else $error("IRQ 14 not owned by ATA controller");

	a_line_level_hold: assert property (
		s_slot3_inta_held ##1 !i_pci_int_n.slot_int_n[2][0]
		|=> !pci_q.slot_int_n[2][0])
		else $error("Held request dropped from line C");

	// Level sensitive: a released source must not stay latched
	a_line_release: assert property (
		s_slot3_inta_idle |=> pci_q.slot_int_n[2][0])
		else $error("Released request still seen on slot 3 INTA");

endmodule

// ===== irq_router_pkg.sv
// Shared types and constants for the shared-line interrupt router
package irq_router_pkg;

	localparam int LINE_NUM = 8;
	localparam int SLOT_NUM = 4;
	localparam int PIN_NUM = 4;
	localparam int IRQ_LEGACY_NUM = 16;
	localparam int IRQ_TOTAL_NUM = 24;
	localparam int IRQ_EXT_BASE = 16;
	localparam int DYN_NUM = 3;
	localparam int SYNC_STAGES = 3;

	// Shared request line indices, line A first
	localparam logic [2:0] LINE_A = 3'h0;
	localparam logic [2:0] LINE_B = 3'h1;
	localparam logic [2:0] LINE_C = 3'h2;
	localparam logic [2:0] LINE_D = 3'h3;
	localparam logic [2:0] LINE_E = 3'h4;
	localparam logic [2:0] LINE_F = 3'h5;
	localparam logic [2:0] LINE_G = 3'h6;
	localparam logic [2:0] LINE_H = 3'h7;

	// Board wiring, indexed [slot][pin], pin 0 is INTA
	localparam logic [3:0][3:0][2:0] SLOT_LINE = {
		{LINE_G, LINE_F, LINE_C, LINE_D},
		{LINE_A, LINE_B, LINE_D, LINE_C},
		{LINE_H, LINE_E, LINE_F, LINE_G},
		{LINE_E, LINE_H, LINE_G, LINE_F}};
	localparam logic [2:0] FW_LINE = LINE_B;

	// Fixed system IRQ numbers
	localparam logic [3:0] IRQ_TIMER = 4'h0;
	localparam logic [3:0] IRQ_KBD = 4'h1;
	localparam logic [3:0] IRQ_CASCADE = 4'h2;
	localparam logic [3:0] IRQ_FLOPPY = 4'h6;
	localparam logic [3:0] IRQ_RTC = 4'h8;
	localparam logic [3:0] IRQ_MOUSE = 4'hC;
	localparam logic [3:0] IRQ_COPRO = 4'hD;
	localparam logic [3:0] IRQ_ATA = 4'hE;
	localparam logic [3:0] IRQ_SERIAL_DEF = 4'h4;
	localparam logic [3:0] IRQ_PARALLEL_DEF = 4'h7;

	// Steerable set: 3,4,5,6,7,9,10,11,12,14,15
	localparam logic [15:0] IRQ_STEER_MASK = 16'hDEF8;

	typedef struct packed {
		logic [3:0][3:0] slot_int_n;
		logic fw_int_n;
	} pci_src_t;

	typedef struct packed {
		logic timer;
		logic kbd;
		logic cascade;
		logic rtc;
		logic copro;
		logic floppy;
		logic first_serial_port;
		logic first_parallel_port;
		logic ata;
		logic mouse;
	} legacy_src_t;

	typedef struct packed {
		logic en;
		logic [3:0] irq;
	} steer_t;

	localparam int PCI_SRC_W = $bits(pci_src_t);
	localparam int LEGACY_SRC_W = $bits(legacy_src_t);

endpackage

// ===== irq_pin_filter.sv
// Three-stage pin synchroniser with second/third stage agreement
`timescale 1ns/1ps
module irq_pin_filter #(
	parameter int WIDTH = 8,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input wire logic i_ref_clk,
	input wire logic i_nrst,
	input wire logic [WIDTH-1:0] i_pin,
	output logic [WIDTH-1:0] o_level
);

	logic [WIDTH-1:0] s1_reg;
	logic [WIDTH-1:0] s2_reg;
	logic [WIDTH-1:0] s3_reg;
	logic [WIDTH-1:0] level_reg;

	always_ff @(posedge i_ref_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			s1_reg <= RST_VAL;
			s2_reg <= RST_VAL;
			s3_reg <= RST_VAL;
		end
		else
		begin
			s1_reg <= i_pin;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end

	// Per bit: a change counts only once stages two and three agree
	always_ff @(posedge i_ref_clk or negedge i_nrst)
	begin
		if (!i_nrst)
			level_reg <= RST_VAL;
		else
			level_reg <= (s2_reg & s3_reg) | (level_reg & (s2_reg ^ s3_reg));
	end

	assign o_level = level_reg;

endmodule

// ===== pci_card_model.sv
// Far-side model: add-in card slots and the onboard 1394 source
`timescale 1ns/1ps
module pci_card_model (
	input wire logic i_ref_clk,
	input wire logic i_nrst,
	input wire logic [15:0] i_req,
	input wire logic i_fw_req,
	input wire logic [11:0] i_card_irqs,
	output irq_router_pkg::pci_src_t o_pins
);
	////////////////////////////////////////////////////////////////////////
	// Pins are pulled up, so idle and reset read high
	always_ff @(posedge i_ref_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			o_pins <= '1;
		end
		else
		begin
			// A card with n interrupts uses INTA first, then B, C, D
			for (int s = 0; s < 4; s++)
			begin
				for (int p = 0; p < 4; p++)
				begin
					o_pins.slot_int_n[s][p] <=
						!(i_req[s*4+p] && p < i_card_irqs[s*3+:3]);
				end
			end
			o_pins.fw_int_n <= !i_fw_req;
		end
	end
endmodule

// ===== pci_irq_line_router_bench.sv
// Self-checking bench for the shared request line router
`timescale 1ns/1ps
module pci_irq_line_router_bench;
	logic i_ref_clk = 1'b0;
	logic i_nrst = 1'b0;
	logic [15:0] req = '0;
	logic fw = 1'b0;
	logic [11:0] cnt = '0;
	irq_router_pkg::pci_src_t pins;
	irq_router_pkg::legacy_src_t leg = '0;
	logic [2:0] dyn = '0;
	logic mode = 1'b0;
	logic mouse = 1'b0;
	logic ata = 1'b0;
	irq_router_pkg::steer_t [7:0] ls = '0;
	irq_router_pkg::steer_t ser = '0;
	irq_router_pkg::steer_t par = '0;
	irq_router_pkg::steer_t [2:0] ds = '0;
	logic [23:0] o_irq;
	logic [7:0] o_line_active;
	logic [31:0] e;
	int seed = 32'h355B9DDB;
	int bad_count = 0;
	int n_checks = 0;
	int line_map [4][4] = '{'{5, 6, 7, 4}, '{6, 5, 4, 7}, '{2, 3, 1, 0},
		'{3, 2, 5, 6}};

	pci_card_model card_u (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst),
		.i_req(req), .i_fw_req(fw), .i_card_irqs(cnt), .o_pins(pins));

	pci_irq_line_router dut_u (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst),
		.i_pci_int_n(pins), .i_legacy_req(leg), .i_dyn_req(dyn),
		.i_extended_vector_mode(mode), .i_mouse_present(mouse),
		.i_ata_present(ata), .i_line_steer(ls), .i_serial_steer(ser),
		.i_parallel_steer(par), .i_dyn_steer(ds), .o_irq(o_irq),
		.o_line_active(o_line_active));

	////////////////////////////////////////////////////////////////////////
	function automatic logic legal(input logic [3:0] n);
		return irq_router_pkg::IRQ_STEER_MASK[n] && !(mouse && n == 4'hC)
			&& !(ata && n == 4'hE);
	endfunction

	function automatic logic [31:0] expect_out();
		logic [7:0] ln;
		logic [23:0] q;
		ln = '0;
		q = '0;
		for (int s = 0; s < 4; s++)
			for (int p = 0; p < 4; p++)
				if (req[s*4+p] && p < cnt[s*3+:3])
					ln[line_map[s][p]] = 1'b1;
		ln[1] = ln[1] | fw;
		if (mode)
			q[23:16] = ln;
		else
			for (int l = 0; l < 8; l++)
				if (ls[l].en && legal(ls[l].irq) && ln[l])
					q[ls[l].irq] = 1'b1;
		q[0] |= leg.timer;
		q[1] |= leg.kbd;
		q[2] |= leg.cascade;
		q[6] |= leg.floppy;
		q[8] |= leg.rtc;
		q[13] |= leg.copro;
		q[12] |= leg.mouse & mouse;
		q[14] |= leg.ata & ata;
		if (!ser.en)
			q[4] |= leg.first_serial_port;
		else if (legal(ser.irq))
			q[ser.irq] |= leg.first_serial_port;
		if (!par.en)
			q[7] |= leg.first_parallel_port;
		else if (legal(par.irq))
			q[par.irq] |= leg.first_parallel_port;
		for (int d = 0; d < 3; d++)
			if (ds[d].en && legal(ds[d].irq))
				q[ds[d].irq] |= dyn[d];
		return {ln, q};
	endfunction

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [23:0] seen, input logic [23:0] want);
		n_checks++;
		if (seen !== want)
		begin
			bad_count++;
			$display("mismatch at %0t: seen %h want %h", $time, seen, want);
		end
	endtask

	task automatic tally_and_finish();
		if (bad_count == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Model flop plus synchroniser plus output register, with margin
	task automatic settle_and_check();
		repeat (7) @(posedge i_ref_clk);
		#1;
		e = expect_out();
		chk({16'h0000, o_line_active}, {16'h0000, e[31:24]});
		chk(o_irq, e[23:0]);
	endtask

	task automatic drive(input int k);
		leg <= 10'($random(seed));
		dyn <= 3'($random(seed));
		ser <= 5'($random(seed));
		par <= 5'($random(seed));
		ds <= 15'($random(seed));
		if (k < 4)
		begin
			req <= 16'hFFFF;
			fw <= 1'b1;
			cnt <= 12'hFFF;
			mode <= (k == 3);
			mouse <= (k == 2);
			ata <= (k == 2);
		end
		else
		begin
			req <= 16'($random(seed));
			fw <= 1'($random(seed));
			cnt <= 12'($random(seed));
			mode <= 1'($random(seed));
			mouse <= 1'($random(seed));
			ata <= 1'($random(seed));
		end
		for (int l = 0; l < 8; l++)
		begin
			// Corners: all on one IRQ, reserved targets, present devices
			if (k == 0)
				ls[l] <= 5'h13;
			else if (k == 1)
				ls[l] <= {1'b1, 4'(l % 2 ? 2 : (l % 3 ? 13 : 8))};
			else if (k == 2)
				ls[l] <= {1'b1, l % 2 ? 4'hC : 4'hE};
			else
				ls[l] <= 5'($random(seed));
		end
	endtask

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		forever #12.5 i_ref_clk = ~i_ref_clk;
	end

	initial
	begin
		repeat (3000) @(posedge i_ref_clk);
		bad_count++;
		tally_and_finish();
	end

	initial
	begin
		repeat (16) @(posedge i_ref_clk);
		i_nrst <= 1'b1;
		for (int k = 0; k < 204; k++)
		begin
			@(posedge i_ref_clk);
			drive(k);
			settle_and_check();
		end
		@(posedge i_ref_clk);
		i_nrst <= 1'b0;
		repeat (2) @(posedge i_ref_clk);
		#1;
		chk(o_irq, 24'h000000);
		chk({16'h0000, o_line_active}, 24'h000000);
		@(posedge i_ref_clk);
		i_nrst <= 1'b1;
		@(posedge i_ref_clk);
		#1;
		chk(o_irq, 24'h000000);
		settle_and_check();
		tally_and_finish();
	end
endmodule
